// *** eibp_pkg.sv ***
// constants shared by the eight-bit port with pattern lock
// assumes a 32-bit apb slave port and 8 pins
`default_nettype none
package eibp_pkg;

   // ****************************************
   // register map
   // ****************************************
   // printed offsets are register indices, byte address is four times
   localparam logic [15:0] EIBP_DIR_IDX = 16'hffd1;
   localparam logic [15:0] EIBP_LAT_IDX = 16'hffd3;
   localparam int EIBP_ADDR_W = 18;
   localparam logic [17:0] EIBP_DIR_ADDR = {EIBP_DIR_IDX, 2'b00};
   localparam logic [17:0] EIBP_LAT_ADDR = {EIBP_LAT_IDX, 2'b00};

   // ****************************************
   // widths and values
   // ****************************************
   localparam int EIBP_PINS = 8;
   localparam logic [7:0] EIBP_DIR_RST = 8'h00;
   localparam logic [7:0] EIBP_LAT_RST = 8'h00;
   localparam logic [7:0] EIBP_TOP_MASK = 8'h80;
   localparam logic [7:0] EIBP_DIR_READ = 8'hff;
   localparam logic [23:0] EIBP_RD_PAD = 24'h00_0000;
   localparam int EIBP_TOP_PIN = 7;

   // ****************************************
   // operating modes
   // ****************************************
   typedef enum logic [2:0] {
      EIBP_MODE_1 = 3'b001,
      EIBP_MODE_3 = 3'b011,
      EIBP_MODE_5 = 3'b101,
      EIBP_MODE_7 = 3'b111
   } eibp_mode_e;

endpackage
`default_nettype wire

// *** eibp_pin_mux.sv ***
// per-pin function selection for the eight-bit port
// assumes all select inputs are settled within one pclk cycle
`timescale 1ns/1ps
`default_nettype none
module eibp_pin_mux
   import eibp_pkg::*;
(
   // port state
   input wire logic [7:0] dir_eff,
   input wire logic [7:0] latch_q,
   input wire logic [7:0] pin_s,
   // alternate functions
   input wire logic [7:0] alt_en,
   input wire logic [7:0] alt_out,
   input wire logic [7:0] alt_oe,
   input wire logic mode3,
   input wire logic addr_top,
   // results
   output logic [7:0] drv_val,
   output logic [7:0] drv_en,
   output logic [7:0] rd_val
);

   // ****************************************
   // one cell per pin
   // ****************************************
   genvar i;
   generate
      for (i = 0; i < EIBP_PINS; i++) begin : g_pin
         wire logic is_addr = mode3 && (i == EIBP_TOP_PIN);
         assign drv_val[i] = is_addr ? addr_top :
                             alt_en[i] ? alt_out[i] : latch_q[i];
         assign drv_en[i] = is_addr ? 1'b1 :
                            alt_en[i] ? alt_oe[i] : dir_eff[i];
         assign rd_val[i] = dir_eff[i] ? latch_q[i] : pin_s[i];
      end
   endgenerate

endmodule
`default_nettype wire

// *** eibp_port.sv ***
// eight-bit io port with pattern lock, apb register slave
// assumes pins synchronous to pclk; standby and mode inputs
// come from the system controller; pattern unit drives lock
//
// Notes on behaviour
// - direction bit one drives, zero inputs
// - mode 3 top pin forced address output
// - direction register reads all ones
// - reset, hardware standby load mode value
// - software standby keeps direction and drive
// - read returns latch or pin level
// - latch clears reset, kept software standby
// - latch holds pattern groups 0 and 1
// - locked latch bits ignore cpu writes
// - locked bits change only by transfer
// - both registers eight bits, bit per pin
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module eibp_port
   import eibp_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // system state
   input wire logic [2:0] mode_sel,
   input wire logic hw_standby,
   input wire logic sw_standby,
   // pattern unit
   input wire logic [7:0] next_data_enable_bank,
   input wire logic [7:0] next_data_buffer,
   input wire logic xfer_strobe,
   // timer and address functions
   input wire logic [7:0] alt_en,
   input wire logic [7:0] alt_out,
   input wire logic [7:0] alt_oe,
   input wire logic addr_top,
   // pins
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe
);

   // ****************************************
   // address decode
   // ****************************************
   // exact word match, low byte-address bits must be zero
   function automatic logic hit(input logic [17:0] a,
                                input logic [17:0] r);
      hit = (a == r);
   endfunction

   logic [7:0] dir_r;       // stored direction bits
   logic [7:0] dir_nxt;
   logic [7:0] latch_r;     // output data latch
   logic [7:0] latch_nxt;
   logic [7:0] pin_s;       // sampled pin levels
   logic [31:0] prdata_r;   // read data register
   logic [7:0] pin_out_r;
   logic [7:0] pin_oe_r;
   logic [7:0] drv_val;
   logic [7:0] drv_en;
   logic [7:0] rd_val;

   wire logic mode3 = (mode_sel == EIBP_MODE_3);
   wire logic dir_hit = hit(paddr, EIBP_DIR_ADDR);
   wire logic lat_hit = hit(paddr, EIBP_LAT_ADDR);
   wire logic any_hit = dir_hit || lat_hit;
   wire logic setup_ph = psel && !penable;
   wire logic access_ph = psel && penable;
   // writes need byte lane 0, where the 8-bit data sits
   wire logic wr_ok = access_ph && pwrite && pstrb[0];
   wire logic dir_wr = wr_ok && dir_hit;
   wire logic lat_wr = wr_ok && lat_hit;
   wire logic [7:0] wbyte = pwdata[7:0];

   // ****************************************
   // direction register
   // ****************************************
   // top bit forced in mode 3
   // forcing on the output side keeps the async reset constant,
   // and makes the mode 3 value appear without a capture step
   wire logic [7:0] top_force = mode3 ? EIBP_TOP_MASK : EIBP_DIR_RST;
   wire logic [7:0] dir_eff = dir_r | top_force;
   // mode 3 write mask: top bit is not writable there
   wire logic [7:0] dir_wmask = ~top_force;

   assign dir_nxt = dir_wr ? (wbyte & dir_wmask) : dir_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_r <= EIBP_DIR_RST;
      end else if (hw_standby) begin
         dir_r <= EIBP_DIR_RST;
      end else begin
         dir_r <= dir_nxt;
      end
   end

   // ****************************************
   // output data latch
   // ****************************************
   // locked bits refuse cpu writes
   wire logic [7:0] cpu_mask = lat_wr ? ~next_data_enable_bank : 8'h00;
   wire logic [7:0] tpu_mask = xfer_strobe ? next_data_enable_bank : 8'h00;

   // latch doubles as pattern holding register
   // cpu and transfer masks are disjoint, so no priority clash
   assign latch_nxt = (latch_r & ~(cpu_mask | tpu_mask)) |
                      (wbyte & cpu_mask) |
                      (next_data_buffer & tpu_mask);

   // cleared by reset and hardware standby
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_r <= EIBP_LAT_RST;
      end else if (hw_standby) begin
         latch_r <= EIBP_LAT_RST;
      end else begin
         latch_r <= latch_nxt;
      end
   end

   // ****************************************
   // pin sampling
   // ****************************************
   // pins are synchronous, one sample stage is enough
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s <= 8'h00;
      end else begin
         pin_s <= pin_in;
      end
   end

   // ****************************************
   // pin function selection
   // ****************************************
   eibp_pin_mux u_mux (
      .dir_eff(dir_eff),
      .latch_q(latch_r),
      .pin_s(pin_s),
      .alt_en(alt_en),
      .alt_out(alt_out),
      .alt_oe(alt_oe),
      .mode3(mode3),
      .addr_top(addr_top),
      .drv_val(drv_val),
      .drv_en(drv_en),
      .rd_val(rd_val)
   );

   // freeze drivers in software standby
   // drivers register one cycle after the latch changes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out_r <= 8'h00;
         pin_oe_r <= 8'h00;
      end else if (hw_standby) begin
         pin_out_r <= 8'h00;
         pin_oe_r <= 8'h00;
      end else if (!sw_standby) begin
         pin_out_r <= drv_val;
         pin_oe_r <= drv_en;
      end
   end

   assign pin_out = pin_out_r;
   assign pin_oe = pin_oe_r;

   // ****************************************
   // apb read and answer
   // ****************************************
   // direction reads back all ones
   wire logic [7:0] rd_byte = dir_hit ? EIBP_DIR_READ :
                              lat_hit ? rd_val : 8'h00;

   // read data captured in setup, held through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         prdata_r <= {EIBP_RD_PAD, rd_byte};
      end
   end

   assign prdata = prdata_r;
   // zero wait states: every access ends in one access cycle
   assign pready = 1'b1;
   // unmapped addresses answer with an error
   assign pslverr = access_ph && !any_hit;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence seq_setup_rd(logic h);
      psel && !penable && !pwrite && h;
   endsequence

   sequence seq_access;
      psel && penable;
   endsequence

   // driver follows direction
   // presetn in the antecedent: flops still reset at the release edge
   AST_DIR_DRIVES: assert property (
      (presetn && !sw_standby && !hw_standby && !alt_en[0]) |=>
         pin_oe[0] == $past(dir_r[0]))
      else $error("pin 0 enable does not follow direction");

   // top direction pinned in mode 3
   AST_MODE3_TOP: assert property (
      (presetn && mode3 && !sw_standby && !hw_standby) |=>
         pin_oe[7] && pin_out[7] == $past(addr_top))
      else $error("mode 3 top pin not address output");

   AST_DIR_READ: assert property (
      seq_setup_rd(dir_hit) ##1 seq_access |->
         prdata == 32'h0000_00ff)
      else $error("direction read not all ones");

   AST_HWSTBY_CLEAR: assert property (
      hw_standby |=> dir_r == 8'h00 && latch_r == 8'h00 &&
         dir_eff == (mode3 ? 8'h80 : 8'h00))
      else $error("hardware standby did not clear");

   AST_SWSTBY_HOLD: assert property (
      (sw_standby && !hw_standby) |=>
         $stable(pin_out) && $stable(pin_oe))
      else $error("pins moved in software standby");

   // port read mixes latch and pins
   AST_PORT_READ: assert property (
      seq_setup_rd(lat_hit) ##1 seq_access |->
         prdata[7:0] == (($past(dir_eff) & $past(latch_r)) |
                         (~$past(dir_eff) & $past(pin_s))))
      else $error("port read value wrong");

   AST_LOCK_WRITE: assert property (
      (lat_wr && !xfer_strobe && !hw_standby) |=>
         ((latch_r ^ $past(latch_r)) &
          $past(next_data_enable_bank)) == 8'h00)
      else $error("locked latch bit took a cpu write");

   AST_XFER_LOAD: assert property (
      (xfer_strobe && !hw_standby) |=>
         ((latch_r ^ $past(next_data_buffer)) &
          $past(next_data_enable_bank)) == 8'h00)
      else $error("transfer did not load locked bits");

   // alternate function drives its pins
   // the top pin belongs to the address output in mode 3
   AST_ALT_DRIVE: assert property (
      (presetn && (alt_en != 8'h00) && !sw_standby && !hw_standby) |=>
         (((pin_out ^ $past(alt_out)) | (pin_oe ^ $past(alt_oe))) &
          $past(alt_en & ~top_force)) == 8'h00)
      else $error("alternate function not on its pins");

   AST_XFER_FREE: assert property (
      (xfer_strobe && !lat_wr && !hw_standby) |=>
         ((latch_r ^ $past(latch_r)) &
          ~$past(next_data_enable_bank)) == 8'h00)
      else $error("transfer touched an unlocked bit");

   AST_UNMAPPED: assert property (
      (seq_access ##0 !any_hit) |-> pslverr && pready)
      else $error("unmapped access not flagged");

   // only the low byte carries data
   AST_READ_WIDTH: assert property (
      prdata[31:8] == 24'h00_0000)
      else $error("read data above bit 7 not zero");

   // write without byte lane 0 dropped
   AST_STRB_IGNORE: assert property (
      (access_ph && pwrite && !pstrb[0] && !xfer_strobe && !hw_standby) |=>
         $stable(latch_r) && $stable(dir_r))
      else $error("write without lane 0 changed a register");

endmodule
`default_nettype wire

// *** eibp_pin_model.sv ***
// pin-side model for the eight-bit port
// assumes the outside world drives ext_lvl where no driver is on
`timescale 1ns/1ps
`default_nettype none
module eibp_pin_model (
   // port drivers
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   // outside level
   input wire logic [7:0] ext_lvl,
   // resolved pins
   output logic [7:0] pin_in
);
   // ****************************************
   // wire resolution
   // ****************************************
   // a driving pin wins over the outside level
   assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the eight-bit port
// assumes eibp_pkg, eibp_port and eibp_pin_model compiled before
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import eibp_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [17:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, er, hws = 0, sws = 0, xfs = 0, atop = 0;
   logic [2:0] mode = 3'b001;
   logic [7:0] neb = '0, nbuf = '0, aen = '0, aout = '0, aoe = '0;
   logic [7:0] ext = 8'h3c, pin_in, pin_out, pin_oe;
   int mismatches = 0, checks = 0;
   // 40 ns clock
   initial begin
      forever #20 pclk = ~pclk;
   end
   eibp_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mode_sel(mode), .hw_standby(hws),
      .sw_standby(sws), .next_data_enable_bank(neb), .next_data_buffer(nbuf),
      .xfer_strobe(xfs), .alt_en(aen), .alt_out(aout), .alt_oe(aoe), .addr_top(atop),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   eibp_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext), .pin_in(pin_in));
   // ****************************************
   // tasks
   // ****************************************
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         mismatches++;
         end_of_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      tick(8);
      presetn <= 1'b1;
      tick(2);
      chk("oe_rst", 8'h00, pin_oe);
      apb(1'b0, EIBP_DIR_ADDR, 8'h00);
      chk("dir_rd", 32'h0000_00ff, rd);
      apb(1'b0, EIBP_LAT_ADDR, 8'h00);
      chk("lat_in", 32'h0000_003c, rd);
      apb(1'b1, EIBP_DIR_ADDR, 8'h0f);
      apb(1'b1, EIBP_LAT_ADDR, 8'ha5);
      tick(2);
      chk("oe_dir", 8'h0f, pin_oe);
      chk("out_lat", 8'h05, pin_out & 8'h0f);
      apb(1'b0, EIBP_LAT_ADDR, 8'h00);
      chk("lat_mix", 32'h0000_0035, rd);
      // locked bits keep their value against cpu writes
      neb <= 8'h03;
      apb(1'b1, EIBP_LAT_ADDR, 8'h5a);
      apb(1'b0, EIBP_LAT_ADDR, 8'h00);
      chk("lat_lock", 32'h0000_0039, rd);
      nbuf <= 8'h02;
      xfs <= 1'b1;
      tick(1);
      xfs <= 1'b0;
      apb(1'b0, EIBP_LAT_ADDR, 8'h00);
      chk("lat_xfer", 32'h0000_003a, rd);
      neb <= 8'h00;
      // a write without byte lane 0 must leave the latch alone
      pstrb <= 4'he;
      apb(1'b1, EIBP_LAT_ADDR, 8'hff);
      pstrb <= 4'hf;
      apb(1'b0, EIBP_LAT_ADDR, 8'h00);
      chk("lat_strb", 32'h0000_003a, rd);
      apb(1'b0, 18'h0_0100, 8'h00);
      chk("unmap_err", 32'h0000_0001, er);
      chk("unmap_rd", 32'h0000_0000, rd);
      // pattern pins need their direction bits set
      apb(1'b1, EIBP_DIR_ADDR, 8'hff);
      // drivers take the new direction one edge later, then freeze
      tick(1);
      sws <= 1'b1;
      // a latch write in standby must not reach the pins
      apb(1'b1, EIBP_LAT_ADDR, 8'ha5);
      tick(2);
      chk("sw_out", 8'h5a, pin_out);
      chk("sw_oe", 8'hff, pin_oe);
      apb(1'b0, EIBP_LAT_ADDR, 8'h00);
      chk("sw_lat", 32'h0000_00a5, rd);
      sws <= 1'b0;
      aen <= 8'h04;
      aout <= 8'h00;
      aoe <= 8'h00;
      tick(3);
      chk("alt_out", 8'ha1, pin_out);
      chk("alt_oe", 8'hfb, pin_oe);
      aen <= 8'h00;
      hws <= 1'b1;
      tick(2);
      hws <= 1'b0;
      tick(2);
      chk("hw_oe", 8'h00, pin_oe);
      apb(1'b1, EIBP_DIR_ADDR, 8'hff);
      apb(1'b0, EIBP_LAT_ADDR, 8'h00);
      chk("hw_lat", 32'h0000_0000, rd);
      // mode 3 restart: top pin carries the address bit
      mode <= 3'b011;
      presetn <= 1'b0;
      atop <= 1'b1;
      tick(2);
      presetn <= 1'b1;
      tick(2);
      chk("m3_oe", 8'h80, pin_oe);
      chk("m3_top", 8'h80, pin_out & 8'h80);
      // clearing the top bit must not take, bit 0 must
      apb(1'b1, EIBP_DIR_ADDR, 8'h01);
      tick(2);
      chk("m3_lock", 8'h81, pin_oe);
      end_of_test();
   end
endmodule
`default_nettype wire
